// >>> core/epoch_time_base_params.svh
// Constants for the epoch time base: register offsets, field positions, reset values, timing.
// Assumes inclusion by bare name from the design and bench files.
`ifndef EPOCH_TIME_BASE_PARAMS_SVH
`define EPOCH_TIME_BASE_PARAMS_SVH

// Register byte offsets on the APB bus.
`define OFS_EPOCH_DIVISOR 12'h000
`define OFS_TIMEBASE_CONFIG 12'h004
`define OFS_EPOCH_CAPTURE 12'h008
`define OFS_IRQ_STATUS 12'h00c
`define OFS_IRQ_MASK 12'h010
`define OFS_SOFT_RESET 12'h014

// Epoch divisor layout: 16 integer bits above 10 fraction bits.
`define DIV_WIDTH 26
`define DIV_FRAC_BITS 10
`define DIV_INT_BITS 16
`define DIV_RESET 26'h0000000
`define DIV_MIN_INT 16'h0004

// Time base configuration fields.
`define CFG_MEAS_RATIO_LSB 0
`define CFG_MEAS_RATIO_W 6
`define CFG_MEAS_EN_BIT 6
`define CFG_PULSE_RATIO_LSB 8
`define CFG_PULSE_RATIO_W 14
`define CFG_PULSE_EN_BIT 22
`define CFG_RESET 23'h000000

// Capture register: interval count in low half, pulse phase above.
`define CAP_INTERVAL_LSB 0
`define CAP_PHASE_LSB 16

// Interrupt status bits.
`define IRQ_EPOCH_BIT 0
`define IRQ_PULSE_BIT 1

// Fixed prescale ahead of the measurement output divider.
`define MEAS_PRESCALE 5'd20

// Output pulse width: 128 core cycles at 20 MHz (6400 ns).
`define CLK_PERIOD_NS 50
`define PULSE_WIDTH_NS 6400
`define PULSE_WIDTH_CYC (`PULSE_WIDTH_NS / `CLK_PERIOD_NS)

`endif

// >>> core/epoch_time_base_pkg.sv
// Types shared by the epoch time base modules.
// Assumes the params header provides all numeric constants.
package epoch_time_base_pkg;
  typedef enum logic [1:0] {apb_idle, apb_setup, apb_access} apb_phase_type;
  typedef logic [31:0] word_type;
endpackage

// >>> core/tick_bus_if.sv
// Interface carrying the epoch tick from the clock divider to the rest of the time base.
// Assumes a single core clock domain.
`timescale 1ns/100ps
interface tick_bus_if;
  logic tick;
  logic [25:0] divisor;
  modport src (output tick, input divisor);
  modport dst (input tick, output divisor);
endinterface // tick_bus_if

// >>> core/frac_epoch_divider.sv
// Fractional divider producing a one-cycle epoch tick from the core clock.
// Assumes divisor integer part of at least 4 and a synchronous active-low reset.
`timescale 1ns/100ps
`include "epoch_time_base_params.svh"
module frac_epoch_divider import epoch_time_base_pkg::*; (
  input wire logic clk, // Core clock
  input wire logic nrst, // Chip reset, synchronous
  tick_bus_if.src tb // Tick out, divisor in
);
  logic [15:0] count_reg;
  logic [9:0] acc_reg;
  logic [10:0] acc_sum;

  assign acc_sum = {1'b0, acc_reg} + {1'b0, tb.divisor[9:0]};
  assign tb.tick = (count_reg == 16'h0000);

  // The divisor is read only on the tick, so a new value starts the next epoch cycle
  // and a running cycle is never cut short.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_reg <= 16'h0000;
      acc_reg <= 10'h000;
    end else if (tb.tick) begin
      acc_reg <= acc_sum[9:0];
      // Period is integer part plus one, plus one more on a carry.
      count_reg <= tb.divisor[25:10] + {15'h0000, acc_sum[10]};
    end else begin
      count_reg <= count_reg - 16'h0001;
    end
  end
endmodule // frac_epoch_divider

// >>> core/epoch_time_base.sv
// Time base: epoch clock, measurement epoch output and input, second pulse, APB registers.
// Assumes meas_epoch_in is synchronous to clk and an APB master on the same clock.
`timescale 1ns/100ps
`include "epoch_time_base_params.svh"

// Behaviour
// - Derive epoch tick by fractional core clock division.
// - New divisor applies from next epoch cycle.
// - Fractional ratio alternates cycle length by one.
// - Synchronise epoch input, detect rising edge.
// - Interrupt on each measurement epoch strobe.
// - Output epoch: divide by 20, then ratio.
// - New output ratio applies next output cycle.
// - Output epoch gated; 128 cycles high when enabled.
// - 16-bit core cycle counter sampled at epoch.
// - Second pulse divides epoch tick by ratio.
// - Interrupt at each second pulse period start, gated or not.
// - Pulse enable gates pin only, divider runs.
// - Second pulse high 128 cycles each period.
// - Pulse path one cycle shorter than strobe.
// - New pulse ratio applies next pulse cycle.
// - Capture pulse divider count at each epoch.
// - Soft reset spares all three dividers.
module epoch_time_base import epoch_time_base_pkg::*; (
  input wire logic clk, // Core clock, 20 MHz
  input wire logic nrst, // Chip reset, synchronous, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic meas_epoch_in, // Measurement epoch input
  output logic meas_epoch_out, // Measurement epoch output
  output logic second_pulse_out, // Pulse per second output
  output logic epoch_mark_strobe, // Internal measurement epoch strobe
  output logic irq // Level interrupt
);
  tick_bus_if tbus();

  logic soft_rst_reg;
  logic rst_all_n;
  logic [25:0] epoch_divisor_reg;
  logic [22:0] timebase_config_reg;
  logic [31:0] epoch_capture_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [31:0] rdata_next;
  logic addr_ok;
  logic wr_en;
  logic rd_en;

  logic [4:0] pre_reg;
  logic [5:0] meas_cnt_reg;
  logic [5:0] meas_ratio_reg;
  logic meas_start;
  logic [7:0] meas_width_reg;

  logic [13:0] pulse_cnt_reg;
  logic [13:0] pulse_ratio_reg;
  logic pulse_start;
  logic pulse_start_reg;
  logic [7:0] pulse_width_reg;
  logic pulse_out_reg;
  logic meas_out_reg;

  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic edge_det;
  logic [15:0] meas_interval_count;

  logic meas_out_en;
  logic second_pulse_en;
  logic [5:0] meas_out_ratio;
  logic [13:0] second_pulse_ratio;

  assign meas_out_ratio = timebase_config_reg[`CFG_MEAS_RATIO_LSB +: `CFG_MEAS_RATIO_W];
  assign meas_out_en = timebase_config_reg[`CFG_MEAS_EN_BIT];
  assign second_pulse_ratio = timebase_config_reg[`CFG_PULSE_RATIO_LSB +: `CFG_PULSE_RATIO_W];
  assign second_pulse_en = timebase_config_reg[`CFG_PULSE_EN_BIT];

  // Soft reset acts one cycle after the write and clears only the synchroniser, interval counter, capture and interrupt registers.
  assign rst_all_n = nrst & ~soft_rst_reg;

  // The divisor survives a soft reset so the epoch tick keeps its phase.
  assign tbus.divisor = epoch_divisor_reg;

  frac_epoch_divider u_div (
    .clk(clk),
    .nrst(nrst),
    .tb(tbus)
  );

  // APB slave: zero wait states.
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pslverr = psel & penable & ~addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    rdata_next = 32'h00000000;
    case (paddr)
      `OFS_EPOCH_DIVISOR: rdata_next = {6'h00, epoch_divisor_reg};
      `OFS_TIMEBASE_CONFIG: rdata_next = {9'h000, timebase_config_reg};
      `OFS_EPOCH_CAPTURE: rdata_next = epoch_capture_reg;
      `OFS_IRQ_STATUS: rdata_next = {30'h00000000, irq_status_reg};
      `OFS_IRQ_MASK: rdata_next = {30'h00000000, irq_mask_reg};
      `OFS_SOFT_RESET: rdata_next = 32'h00000000;
      default: addr_ok = 1'b0;
    endcase
  end

  assign prdata = rd_en ? rdata_next : 32'h00000000;

  // Divisor register: software supplies core over epoch frequency minus one.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      epoch_divisor_reg <= `DIV_RESET;
    end else if (wr_en && paddr == `OFS_EPOCH_DIVISOR) begin
      epoch_divisor_reg <= pwdata[25:0];
    end
  end

  // Configuration steers the divider ratios, so it too survives a soft reset.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      timebase_config_reg <= `CFG_RESET;
    end else if (wr_en && paddr == `OFS_TIMEBASE_CONFIG) begin
      timebase_config_reg <= pwdata[22:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_en && paddr == `OFS_SOFT_RESET;
    end
  end

  // Measurement output divider: prescale by 20, then by the latched ratio.
  assign meas_start = tbus.tick && pre_reg == 5'd0 && meas_cnt_reg == 6'd0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_reg <= 5'd0;
      meas_cnt_reg <= 6'd0;
      meas_ratio_reg <= 6'd0;
    end else if (tbus.tick) begin
      pre_reg <= (pre_reg == 5'd0) ? `MEAS_PRESCALE - 5'd1 : pre_reg - 5'd1;
      if (pre_reg == 5'd0) begin
        if (meas_cnt_reg == 6'd0) begin
          // Ratio field holds ratio minus one; it is latched only here.
          meas_ratio_reg <= meas_out_ratio;
          meas_cnt_reg <= meas_out_ratio;
        end else begin
          meas_cnt_reg <= meas_cnt_reg - 6'd1;
        end
      end
    end
  end

  // Output stays low while disabled; otherwise high for 128 cycles from period start.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meas_width_reg <= 8'd0;
      meas_out_reg <= 1'b0;
    end else if (meas_start && meas_out_en) begin
      meas_width_reg <= 8'(`PULSE_WIDTH_CYC - 1);
      meas_out_reg <= 1'b1;
    end else if (meas_width_reg != 8'd0 && meas_out_en) begin
      meas_width_reg <= meas_width_reg - 8'd1;
    end else begin
      meas_width_reg <= 8'd0;
      meas_out_reg <= 1'b0;
    end
  end

  // Second pulse divider: ratio field holds ratio minus one.
  assign pulse_start = tbus.tick && pulse_cnt_reg == 14'd0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pulse_cnt_reg <= 14'd0;
      pulse_ratio_reg <= 14'd0;
    end else if (tbus.tick) begin
      if (pulse_cnt_reg == 14'd0) begin
        pulse_ratio_reg <= second_pulse_ratio;
        pulse_cnt_reg <= second_pulse_ratio;
      end else begin
        pulse_cnt_reg <= pulse_cnt_reg - 14'd1;
      end
    end
  end

  // The output epoch leaves one flip-flop after the tick and the strobe two more later on a
  // direct loopback; this extra stage puts the pulse edge exactly one cycle ahead.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pulse_start_reg <= 1'b0;
    end else begin
      pulse_start_reg <= pulse_start;
    end
  end

  // A pulse is released only at its start, so enabling mid-period never gives a stub.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pulse_width_reg <= 8'd0;
      pulse_out_reg <= 1'b0;
    end else if (pulse_start_reg && second_pulse_en) begin
      pulse_width_reg <= 8'(`PULSE_WIDTH_CYC - 1);
      pulse_out_reg <= 1'b1;
    end else if (pulse_width_reg != 8'd0 && second_pulse_en) begin
      pulse_width_reg <= pulse_width_reg - 8'd1;
    end else begin
      pulse_width_reg <= 8'd0;
      pulse_out_reg <= 1'b0;
    end
  end

  // Enable gates only the pin; divider and interrupt keep running.
  assign second_pulse_out = pulse_out_reg & second_pulse_en;
  assign meas_epoch_out = meas_out_reg;

  // Two-stage synchroniser, then a third stage for edge detection.
  always_ff @(posedge clk) begin
    if (!rst_all_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= meas_epoch_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign edge_det = sync2_reg & ~sync3_reg;
  assign epoch_mark_strobe = edge_det;

  // Free-running 16-bit cycle counter, restarted after each epoch.
  always_ff @(posedge clk) begin
    if (!rst_all_n) begin
      meas_interval_count <= 16'h0000;
    end else if (edge_det) begin
      meas_interval_count <= 16'h0001;
    end else begin
      meas_interval_count <= meas_interval_count + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_all_n) begin
      epoch_capture_reg <= 32'h00000000;
    end else if (edge_det) begin
      epoch_capture_reg[`CAP_INTERVAL_LSB +: 16] <= meas_interval_count;
      epoch_capture_reg[`CAP_PHASE_LSB +: 16] <= {2'b00, pulse_cnt_reg};
    end
  end

  // Sticky status; a read clears, but an event in the same cycle wins.
  always_ff @(posedge clk) begin
    if (!rst_all_n) begin
      irq_status_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rd_en && paddr == `OFS_IRQ_STATUS) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
      if (edge_det) begin
        irq_status_reg[`IRQ_EPOCH_BIT] <= 1'b1;
      end
      if (pulse_start) begin
        irq_status_reg[`IRQ_PULSE_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_all_n) begin
      irq_mask_reg <= 2'b00;
    end else if (wr_en && paddr == `OFS_IRQ_MASK) begin
      irq_mask_reg <= pwdata[1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);
endmodule // epoch_time_base

// >>> tb/epoch_time_base_sva.sv
// Checker for the epoch time base, watching only the top module ports.
// Assumes it is bound onto epoch_time_base and a single core clock domain.
`timescale 1ns/100ps
`include "epoch_time_base_params.svh"
module epoch_time_base_sva (
  input wire logic clk, // Core clock
  input wire logic nrst, // Chip reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic meas_epoch_in, // Epoch input
  input wire logic meas_epoch_out, // Epoch output
  input wire logic second_pulse_out, // Second pulse
  input wire logic epoch_mark_strobe // Epoch strobe
);
  logic [9:0] meas_high_cnt;
  logic [9:0] pulse_high_cnt;
  wire acc = psel && penable;
  always_ff @(posedge clk) begin
    meas_high_cnt <= (!nrst || !meas_epoch_out) ? 10'h000 : meas_high_cnt + 10'h001;
  end
  always_ff @(posedge clk) begin
    pulse_high_cnt <= (!nrst || !second_pulse_out) ? 10'h000 : pulse_high_cnt + 10'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_in_rise; $rose(meas_epoch_in); endsequence
  sequence s_mark; ##[2:3] epoch_mark_strobe ##1 !epoch_mark_strobe; endsequence
  property p_strobe; s_in_rise |-> s_mark; endproperty
  property p_strobe_one; epoch_mark_strobe |=> !epoch_mark_strobe; endproperty
  property p_ready; acc |-> pready; endproperty
  property p_unmapped; acc && paddr > `OFS_SOFT_RESET |-> pslverr && prdata == 32'h0; endproperty
  property p_mapped;
    acc && paddr <= `OFS_SOFT_RESET && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  property p_idle; !acc |-> prdata == 32'h0 && !pslverr; endproperty
  property p_meas_width; $fell(meas_epoch_out) |-> meas_high_cnt == 10'h080; endproperty
  property p_meas_max; meas_epoch_out |-> meas_high_cnt < 10'h080; endproperty
  property p_meas_gap; $fell(meas_epoch_out) |-> !meas_epoch_out [*8]; endproperty
  property p_pulse_width; $fell(second_pulse_out) |-> pulse_high_cnt == 10'h080; endproperty
  a_strobe: assert property (p_strobe) else $error("epoch strobe missing after input edge");
  a_strobe_one: assert property (p_strobe_one) else $error("epoch strobe too long");
  a_ready: assert property (p_ready) else $error("ready low in access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  a_idle: assert property (p_idle) else $error("bus outputs active when idle");
  a_meas_width: assert property (p_meas_width) else $error("output epoch width wrong");
  a_meas_max: assert property (p_meas_max) else $error("output epoch too long");
  a_meas_gap: assert property (p_meas_gap) else $error("output epoch gap short");
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
endmodule // epoch_time_base_sva
bind epoch_time_base epoch_time_base_sva u_sva (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .meas_epoch_in(meas_epoch_in), .meas_epoch_out(meas_epoch_out),
  .second_pulse_out(second_pulse_out), .epoch_mark_strobe(epoch_mark_strobe));

// >>> tb/epoch_loop_model.sv
// Far side model: the output epoch wired back to the epoch input, as in a lone receiver.
// Assumes the core clock; the wire is registered once so it changes just after an edge.
`timescale 1ns/100ps
module epoch_loop_model (
  input wire logic clk, // Core clock
  input wire logic from_dut, // Output epoch from the block
  input wire logic loop_en, // Loop connected
  output logic to_dut = 1'b0 // Epoch input to the block
);
  always_ff @(posedge clk) begin
    to_dut <= loop_en ? from_dut : 1'b0;
  end
endmodule // epoch_loop_model

// >>> tb/tb.sv
// Self-checking bench for the epoch time base with a loopback far side.
// Assumes the params header on the include path and the checker bound by its own file.
`timescale 1ns/100ps
`include "epoch_time_base_params.svh"
module tb import epoch_time_base_pkg::*;;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, loop_en = 1'b0;
  logic [11:0] paddr = 12'h000;
  word_type pwdata = 32'h0, prdata, seed = 32'hcf862ca1, m;
  logic pready, pslverr, meas_epoch_in, meas_epoch_out, second_pulse_out, epoch_mark_strobe, irq;
  int num_errors = 0, total_checks = 0, cyc = 0, r, n;
  word_type exp_q[$], msk_q[$];
  always #25 clk = ~clk;
  epoch_time_base u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_epoch_in(meas_epoch_in), .meas_epoch_out(meas_epoch_out),
    .second_pulse_out(second_pulse_out), .epoch_mark_strobe(epoch_mark_strobe), .irq(irq));
  epoch_loop_model u_far (.clk(clk), .from_dut(meas_epoch_out), .loop_en(loop_en),
    .to_dut(meas_epoch_in));
  function automatic word_type xs(input word_type s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic word_type cfg(input int ratio, input logic pe);
    return word_type'(ratio - 1) | 32'h40 | 32'hf00 | {9'h000, pe, 22'h0};
  endfunction
  function automatic logic sig(input int s);
    return s == 0 ? meas_epoch_out : s == 1 ? second_pulse_out : epoch_mark_strobe;
  endfunction
  task automatic check(input word_type seen, input word_type exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Called just after a rising edge; returns one idle edge after the access.
  task automatic apb(input logic w, input logic [11:0] a, input word_type d, input word_type k);
    if (!w) begin
      exp_q.push_back(d);
      msk_q.push_back(k);
    end
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rise(input int s);
    @(posedge clk);
    while (sig(s) !== 1'b0) @(posedge clk);
    while (sig(s) !== 1'b1) @(posedge clk);
  endtask
  task automatic fall(input int s);
    rise(s);
    while (sig(s) !== 1'b0) @(posedge clk);
  endtask
  task automatic per(input int s, output int c);
    rise(s);
    c = 0;
    while (sig(s) !== 1'b0) begin @(posedge clk); c++; end
    while (sig(s) !== 1'b1) begin @(posedge clk); c++; end
  endtask
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready) begin
      m = msk_q.pop_front();
      check(prdata & m, exp_q.pop_front() & m);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin num_errors++; wrap_up(); end
  end
  initial begin
    seed = xs(seed);
    r = int'(seed % 3) + 1;
    repeat (4) @(posedge clk);
    nrst <= 1'b1; loop_en <= 1'b1;
    @(posedge clk);
    apb(1, `OFS_EPOCH_DIVISOR, 32'h2400, 0);
    apb(1, `OFS_TIMEBASE_CONFIG, cfg(r, 1), 0);
    apb(0, `OFS_EPOCH_DIVISOR, 32'h2400, 32'h3ffffff);
    apb(0, `OFS_TIMEBASE_CONFIG, cfg(r, 1), 32'h7fffff);
    apb(0, 12'h018, 32'h0, '1);
    $display("test registers done");
    per(0, n); per(0, n); check(n, 200 * r);
    per(1, n); check(n, 160);
    per(2, n); check(n, 200 * r);
    rise(2); @(posedge clk);
    apb(0, `OFS_EPOCH_CAPTURE, 200 * r, 32'hffff);
    $display("test dividers done");
    apb(1, `OFS_IRQ_MASK, 32'h1, 0);
    rise(2); repeat (2) @(posedge clk); check(irq, 1);
    apb(0, `OFS_IRQ_STATUS, 32'h1, 32'h1);
    check(irq, 0);
    $display("test epoch interrupt done");
    apb(1, `OFS_IRQ_MASK, 32'h2, 0);
    fall(1);
    apb(1, `OFS_TIMEBASE_CONFIG, cfg(r, 0), 0);
    apb(0, `OFS_IRQ_STATUS, 32'h2, 32'h2);
    n = 0;
    repeat (400) begin @(posedge clk); if (second_pulse_out !== 1'b0) n++; end
    check(n, 0);
    check(irq, 1);
    $display("test pulse gating done");
    apb(1, `OFS_TIMEBASE_CONFIG, cfg(1, 1), 0);
    apb(1, `OFS_EPOCH_DIVISOR, 32'h2600, 0);
    per(0, n); per(0, n); check(n, 210);
    $display("test fraction done");
    fall(0);
    seed = xs(seed);
    apb(1, `OFS_SOFT_RESET, seed, 0);
    apb(0, `OFS_IRQ_MASK, 32'h0, '1);
    apb(0, `OFS_TIMEBASE_CONFIG, cfg(1, 1), 32'h7fffff);
    per(0, n); check(n, 210);
    $display("test soft reset done");
    wrap_up();
  end
endmodule // tb
